/* core/fcas_top.sv */
// Flash command sequencer: address registers, area select, status word.
// Assumes a flash core on the same clock that answers each operation.
//
// What this block does
// - Area select bit: 0 targets user area, 1 extended user area.
// - Start address ignores bits 31..24 for code, 31..19 for data.
// - Start address bits below the command boundary are dropped.
// - Boundaries: 256 B, 4 B, 8 or 32 KB, 64 B, 16 B per command.
// - Code mode, user area: start outside implemented array flags error.
// - Data mode: start above implemented data size flags error.
// - Configuration command errors outside the allowed window of 0x40..0xFF.
// - OTP setting command errors outside its allowed window.
// - Blank check end must follow the direction bit, else lock.
// - Blank check ignores end bits 31..19, 1 and 0.
// - Blank check end above implemented data size flags error.
// - Start and end addresses reset also on setup initialise.
// - Status word is read-only, any lane width, resets to 0x8000.
// - Bit 18 shows ECC buffer full; writes then wait.
// - Bit 17 set on OTP double error, locks, cleared by clear/stop.
// - Bit 16 set on OTP single correction, no lock, cleared alike.
// - Ready low during processing; high on done, suspend or stop end.
// - Ready drops at first write for program family, else at last.
// - Bit 14 set and lock on illegal command, access or entry.
// - Illegal flag clears only with no violation; stop restores it.
// - Code violation sets its flag, the illegal flag and lock.
// - Data violation sets its flag, the illegal flag and lock.
`timescale 1ns/1ns
module fcas_top (
	input wire logic clk,
	input wire logic rst,
	input wire fcas_pkg::fcas_bus_req_t bus,
	output logic bus_ack,
	output logic [31:0] bus_rdata,
	output fcas_pkg::fcas_core_cmd_t core_cmd,
	input wire fcas_pkg::fcas_core_rsp_t core_rsp,
	output logic ecc_valid,
	output logic [31:0] ecc_word
);
	typedef struct packed {
		fcas_pkg::fcas_seq_t seq;
		logic ready;
		logic illegal;
		logic otp_dbl;
		logic otp_sgl;
		logic code_access_violation;
		logic data_access_violation;
		logic cmdlk;
		logic susp;
		logic region;
		logic entry_c;
		logic entry_d;
		logic bc_dir;
		logic [31:0] start;
		logic [31:0] end_a;
		fcas_pkg::fcas_op_t op;
		logic ack;
		logic [31:0] rdata;
		fcas_pkg::fcas_core_cmd_t cmd;
	} fcas_state_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
		hit = a[31:2] == b[31:2];
	endfunction

	function automatic fcas_pkg::fcas_op_t decode(input logic [7:0] c,
		input logic code_mode, input logic data_mode);
		decode = fcas_pkg::OP_NONE;
		if (code_mode) begin
			case (c)
			fcas_pkg::CMD_PROG: decode = fcas_pkg::OP_PROG_C;
			fcas_pkg::CMD_ERASE: decode = fcas_pkg::OP_ERASE_C;
			fcas_pkg::CMD_CFG: decode = fcas_pkg::OP_CFG;
			fcas_pkg::CMD_OTP: decode = fcas_pkg::OP_OTP;
			fcas_pkg::CMD_LOCK_PROG: decode = fcas_pkg::OP_LOCK_PROG;
			fcas_pkg::CMD_LOCK_READ: decode = fcas_pkg::OP_LOCK_READ;
			default: decode = fcas_pkg::OP_NONE;
			endcase
		end else if (data_mode) begin
			case (c)
			fcas_pkg::CMD_PROG: decode = fcas_pkg::OP_PROG_D;
			fcas_pkg::CMD_DMA: decode = fcas_pkg::OP_DMA;
			fcas_pkg::CMD_ERASE: decode = fcas_pkg::OP_ERASE_D;
			fcas_pkg::CMD_BLANK: decode = fcas_pkg::OP_BLANK;
			default: decode = fcas_pkg::OP_NONE;
			endcase
		end
	endfunction

	fcas_state_t s;
	fcas_state_t next_s;
	fcas_pkg::fcas_check_t chk;
	fcas_pkg::fcas_op_t dec;
	fcas_pkg::fcas_op_t chk_op;
	logic ecc_ready;
	logic ecc_push;
	logic take;
	logic cmd_wr;
	logic [7:0] code;
	logic prog_family;
	logic [31:0] status_word;
	logic [31:0] access_word;

	// ------------------------------------------------------------
	// Checker and dummy ECC buffer
	// ------------------------------------------------------------
	assign dec = decode(bus.wdata[7:0], s.entry_c, s.entry_d);
	assign chk_op = s.seq == fcas_pkg::S_IDLE ? dec : s.op;

	fcas_addr_check u_check (
		.op(chk_op),
		.region(s.region),
		.bc_dir(s.bc_dir),
		.start(s.start),
		.end_a(s.end_a),
		.chk(chk)
	);

	fcas_ecc_buf u_ecc (
		.clk(clk),
		.rst(rst),
		.wr_valid(ecc_push),
		.wr_ready(ecc_ready),
		.wr_data(bus.wdata),
		.rd_valid(ecc_valid),
		.rd_ready(core_rsp.ecc_pop),
		.rd_data(ecc_word)
	);

	// Stalled write holds off the answer until a slot frees
	assign take = bus.req && !s.ack &&
		!(bus.wr && hit(bus.addr, fcas_pkg::DUMMY_ECC_ADDR) && !ecc_ready);
	assign ecc_push = take && bus.wr && hit(bus.addr, fcas_pkg::DUMMY_ECC_ADDR);
	assign cmd_wr = take && bus.wr && hit(bus.addr, fcas_pkg::CMD_AREA_ADDR);
	assign code = bus.wdata[7:0];

	always_comb begin
		status_word = '0;
		status_word[fcas_pkg::ST_ECC_FULL] = !ecc_ready;
		status_word[fcas_pkg::ST_OTP_DOUBLE] = s.otp_dbl;
		status_word[fcas_pkg::ST_OTP_SINGLE] = s.otp_sgl;
		status_word[fcas_pkg::ST_READY] = s.ready;
		status_word[fcas_pkg::ST_ILLEGAL] = s.illegal;
		access_word = '0;
		access_word[fcas_pkg::AS_CODE_VIOL] = s.code_access_violation;
		access_word[fcas_pkg::AS_CMD_LOCK] = s.cmdlk;
		access_word[fcas_pkg::AS_DATA_VIOL] = s.data_access_violation;
		prog_family = dec inside {fcas_pkg::OP_PROG_C, fcas_pkg::OP_PROG_D,
			fcas_pkg::OP_DMA, fcas_pkg::OP_CFG, fcas_pkg::OP_OTP};
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.ack = take;
		next_s.cmd.start = 1'b0;
		next_s.cmd.suspend = 1'b0;
		next_s.cmd.resume = 1'b0;
		next_s.cmd.stop = 1'b0;

		// Register reads; whole word returned, master picks its lanes
		if (take && !bus.wr) begin
			if (hit(bus.addr, fcas_pkg::STATUS_ADDR)) begin
				next_s.rdata = status_word;
			end else if (hit(bus.addr, fcas_pkg::ACCESS_ADDR)) begin
				next_s.rdata = access_word;
			end else if (hit(bus.addr, fcas_pkg::START_ADDR)) begin
				next_s.rdata = s.start;
			end else if (hit(bus.addr, fcas_pkg::END_ADDR)) begin
				next_s.rdata = s.end_a;
			end else if (hit(bus.addr, fcas_pkg::REGION_ADDR)) begin
				next_s.rdata = 32'(s.region) << fcas_pkg::REGION_BIT;
			end else if (hit(bus.addr, fcas_pkg::ENTRY_ADDR)) begin
				next_s.rdata = (32'(s.entry_d) << fcas_pkg::ENTRY_DATA_BIT) |
					(32'(s.entry_c) << fcas_pkg::ENTRY_CODE_BIT);
			end else if (hit(bus.addr, fcas_pkg::BLANK_CTRL_ADDR)) begin
				next_s.rdata = 32'(s.bc_dir) << fcas_pkg::DIR_BIT;
			end else begin
				next_s.rdata = '0;
			end
		end

		// Register writes; the status word ignores writes
		if (take && bus.wr) begin
			if (hit(bus.addr, fcas_pkg::START_ADDR)) begin
				next_s.start = merge(s.start, bus.wdata, bus.be);
			end else if (hit(bus.addr, fcas_pkg::END_ADDR)) begin
				next_s.end_a = merge(s.end_a, bus.wdata, bus.be);
			end else if (hit(bus.addr, fcas_pkg::SETUP_ADDR) &&
				bus.wdata[fcas_pkg::SETUP_BIT]) begin
				next_s.start = '0;
				next_s.end_a = '0;
				next_s.region = 1'b0;
				next_s.entry_c = 1'b0;
				next_s.entry_d = 1'b0;
			end else if (hit(bus.addr, fcas_pkg::REGION_ADDR) &&
				bus.wdata[15:8] == fcas_pkg::REGION_KEY) begin
				next_s.region = bus.wdata[fcas_pkg::REGION_BIT];
			end else if (hit(bus.addr, fcas_pkg::ENTRY_ADDR) && s.ready &&
				bus.wdata[15:8] == fcas_pkg::ENTRY_KEY) begin
				next_s.entry_c = bus.wdata[fcas_pkg::ENTRY_CODE_BIT];
				next_s.entry_d = bus.wdata[fcas_pkg::ENTRY_DATA_BIT];
				if (bus.wdata[fcas_pkg::ENTRY_CODE_BIT] &&
					bus.wdata[fcas_pkg::ENTRY_DATA_BIT]) begin
					next_s.illegal = 1'b1;
					next_s.cmdlk = 1'b1;
				end
			end else if (hit(bus.addr, fcas_pkg::BLANK_CTRL_ADDR)) begin
				next_s.bc_dir = bus.wdata[fcas_pkg::DIR_BIT];
			end else if (hit(bus.addr, fcas_pkg::ACCESS_ADDR)) begin
				if (!bus.wdata[fcas_pkg::AS_CODE_VIOL]) begin
					next_s.code_access_violation = 1'b0;
				end
				if (!bus.wdata[fcas_pkg::AS_DATA_VIOL]) begin
					next_s.data_access_violation = 1'b0;
				end
			end
		end

		// Command area writes
		if (cmd_wr && code == fcas_pkg::CMD_STOP) begin
			next_s.otp_dbl = 1'b0;
			next_s.otp_sgl = 1'b0;
			next_s.illegal = 1'b0;
			next_s.ready = 1'b0;
			next_s.susp = 1'b0;
			next_s.seq = fcas_pkg::S_STOP;
			next_s.cmd.stop = 1'b1;
		end else if (cmd_wr) begin
			case (s.seq)
			fcas_pkg::S_IDLE: begin
				if (code == fcas_pkg::CMD_CLEAR) begin
					next_s.otp_dbl = 1'b0;
					next_s.otp_sgl = 1'b0;
					if (!s.code_access_violation && !s.data_access_violation) begin
						next_s.illegal = 1'b0;
						next_s.cmdlk = 1'b0;
					end
				end else if (s.cmdlk) begin
					next_s.seq = fcas_pkg::S_IDLE;
				end else if (dec == fcas_pkg::OP_NONE) begin
					next_s.illegal = 1'b1;
					next_s.cmdlk = 1'b1;
				end else if (chk.code_viol || chk.data_viol ||
					chk.range_err || chk.dir_err) begin
					next_s.code_access_violation = chk.code_viol;
					next_s.data_access_violation = chk.data_viol;
					next_s.illegal = 1'b1;
					next_s.cmdlk = 1'b1;
				end else begin
					next_s.op = dec;
					next_s.seq = fcas_pkg::S_COLLECT;
					next_s.ready = !prog_family;
				end
			end
			fcas_pkg::S_COLLECT: begin
				if (code == fcas_pkg::CMD_CONFIRM) begin
					next_s.ready = 1'b0;
					next_s.seq = fcas_pkg::S_BUSY;
					next_s.cmd.start = 1'b1;
					next_s.cmd.op = s.op;
					next_s.cmd.region = s.region;
					next_s.cmd.addr = chk.addr;
					next_s.cmd.end_addr = chk.end_addr;
				end else begin
					next_s.illegal = 1'b1;
					next_s.cmdlk = 1'b1;
					next_s.ready = 1'b1;
					next_s.seq = fcas_pkg::S_IDLE;
				end
			end
			fcas_pkg::S_BUSY: begin
				if (code == fcas_pkg::CMD_SUSPEND && !s.susp &&
					s.op inside {fcas_pkg::OP_PROG_C, fcas_pkg::OP_PROG_D,
					fcas_pkg::OP_ERASE_C, fcas_pkg::OP_ERASE_D}) begin
					next_s.susp = 1'b1;
					next_s.cmd.suspend = 1'b1;
				end else begin
					next_s.illegal = 1'b1;
					next_s.cmdlk = 1'b1;
				end
			end
			fcas_pkg::S_SUSP: begin
				if (code == fcas_pkg::CMD_CONFIRM && !s.cmdlk) begin
					next_s.ready = 1'b0;
					next_s.seq = fcas_pkg::S_BUSY;
					next_s.cmd.resume = 1'b1;
				end else if (!s.cmdlk) begin
					next_s.illegal = 1'b1;
					next_s.cmdlk = 1'b1;
				end
			end
			default: begin
				next_s.seq = s.seq;
			end
			endcase
		end

		// Flash core answers
		if (s.seq == fcas_pkg::S_BUSY) begin
			if (core_rsp.otp_double) begin
				next_s.otp_dbl = 1'b1;
				next_s.cmdlk = 1'b1;
			end
			if (core_rsp.otp_single) begin
				next_s.otp_sgl = 1'b1;
			end
			if (core_rsp.done) begin
				next_s.ready = 1'b1;
				next_s.susp = 1'b0;
				next_s.seq = s.susp ? fcas_pkg::S_SUSP : fcas_pkg::S_IDLE;
			end
		end else if (s.seq == fcas_pkg::S_STOP && core_rsp.done) begin
			next_s.ready = 1'b1;
			next_s.illegal = s.code_access_violation || s.data_access_violation;
			next_s.cmdlk = s.code_access_violation || s.data_access_violation;
			next_s.seq = fcas_pkg::S_IDLE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign bus_ack = s.ack;
	assign bus_rdata = s.rdata;
	assign core_cmd = s.cmd;
endmodule

/* core/fcas_pkg.sv */
// Shared constants, codes and carrier types of the flash command sequencer.
// Assumes one clock and a word-addressed view of the peripheral bus.
package fcas_pkg;
	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [31:0] STATUS_ADDR = 32'hFFA10080;
	localparam logic [31:0] REGION_ADDR = 32'hFFA10020;
	localparam logic [31:0] ENTRY_ADDR = 32'hFFA10084;
	localparam logic [31:0] CMD_AREA_ADDR = 32'hFFA20000;
	localparam logic [31:0] ACCESS_ADDR = 32'hFFA10010;
	localparam logic [31:0] START_ADDR = 32'hFFA10030;
	localparam logic [31:0] END_ADDR = 32'hFFA10034;
	localparam logic [31:0] DUMMY_ECC_ADDR = 32'hFFA10088;
	localparam logic [31:0] SETUP_ADDR = 32'hFFA1008C;
	localparam logic [31:0] BLANK_CTRL_ADDR = 32'hFFA100D0;
	// ------------------------------------------------------------
	// Field positions, keys and reset values
	// ------------------------------------------------------------
	localparam logic [31:0] STATUS_RESET = 32'h00008000;
	localparam int ST_ECC_FULL = 18;
	localparam int ST_OTP_DOUBLE = 17;
	localparam int ST_OTP_SINGLE = 16;
	localparam int ST_READY = 15;
	localparam int ST_ILLEGAL = 14;
	localparam int AS_CODE_VIOL = 7;
	localparam int AS_CMD_LOCK = 4;
	localparam int AS_DATA_VIOL = 3;
	localparam int REGION_BIT = 1;
	localparam int ENTRY_DATA_BIT = 7;
	localparam int ENTRY_CODE_BIT = 0;
	localparam int SETUP_BIT = 0;
	localparam int DIR_BIT = 0;
	localparam logic [7:0] REGION_KEY = 8'hA5;
	localparam logic [7:0] ENTRY_KEY = 8'hAA;
	// ------------------------------------------------------------
	// Command codes written to the command area
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_PROG = 8'hE8;
	localparam logic [7:0] CMD_DMA = 8'hEA;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_BLANK = 8'h71;
	localparam logic [7:0] CMD_CFG = 8'h40;
	localparam logic [7:0] CMD_OTP = 8'h45;
	localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
	localparam logic [7:0] CMD_LOCK_READ = 8'h78;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_STOP = 8'hB3;
	localparam logic [7:0] CMD_CLEAR = 8'h50;
	// ------------------------------------------------------------
	// Address limits and buffer size
	// ------------------------------------------------------------
	localparam logic [23:0] CODE_USER_END = 24'h200000;
	localparam logic [23:0] SMALL_BLOCK_END = 24'h010000;
	localparam logic [18:0] DATA_END = 19'h10000;
	localparam logic [18:0] SET_LO = 19'h00040;
	localparam logic [18:0] SET_HI = 19'h000FF;
	localparam int ECC_DEPTH = 4;
	localparam int ECC_PTR_W = 2;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_PROG_C = 4'h1, OP_PROG_D = 4'h2, OP_DMA = 4'h3,
		OP_ERASE_C = 4'h4, OP_ERASE_D = 4'h5, OP_BLANK = 4'h6,
		OP_CFG = 4'h7, OP_LOCK_PROG = 4'h8, OP_LOCK_READ = 4'h9,
		OP_OTP = 4'hA
	} fcas_op_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_COLLECT = 3'b001, S_BUSY = 3'b010,
		S_SUSP = 3'b011, S_STOP = 3'b100
	} fcas_seq_t;

	typedef struct packed {
		logic req;
		logic wr;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
	} fcas_bus_req_t;

	typedef struct packed {
		logic start;
		logic suspend;
		logic resume;
		logic stop;
		fcas_op_t op;
		logic region;
		logic [31:0] addr;
		logic [31:0] end_addr;
	} fcas_core_cmd_t;

	typedef struct packed {
		logic done;
		logic otp_single;
		logic otp_double;
		logic ecc_pop;
	} fcas_core_rsp_t;

	typedef struct packed {
		logic code_viol;
		logic data_viol;
		logic range_err;
		logic dir_err;
		logic [31:0] addr;
		logic [31:0] end_addr;
	} fcas_check_t;
endpackage

/* core/fcas_addr_check.sv */
// Address truncation, alignment and range checks for one command.
// Purely combinational; the caller samples the result.
`timescale 1ns/1ns
module fcas_addr_check (
	input wire fcas_pkg::fcas_op_t op,
	input wire logic region,
	input wire logic bc_dir,
	input wire logic [31:0] start,
	input wire logic [31:0] end_a,
	output fcas_pkg::fcas_check_t chk
);
	function automatic logic outside(input logic [18:0] a);
		outside = (a < fcas_pkg::SET_LO) || (a > fcas_pkg::SET_HI);
	endfunction

	logic [18:0] s_lo;
	logic [18:0] e_lo;
	logic code_op;
	logic data_op;

	always_comb begin
		s_lo = start[18:0];
		e_lo = end_a[18:0];
		code_op = op inside {fcas_pkg::OP_PROG_C, fcas_pkg::OP_ERASE_C,
			fcas_pkg::OP_LOCK_PROG, fcas_pkg::OP_LOCK_READ};
		data_op = op inside {fcas_pkg::OP_PROG_D, fcas_pkg::OP_DMA,
			fcas_pkg::OP_ERASE_D, fcas_pkg::OP_BLANK};
		chk = '0;
		chk.code_viol = code_op && !region &&
			start[23:0] >= fcas_pkg::CODE_USER_END;
		chk.data_viol = data_op && s_lo >= fcas_pkg::DATA_END;
		chk.range_err = (op == fcas_pkg::OP_CFG && outside(s_lo)) ||
			(op == fcas_pkg::OP_OTP && outside(s_lo)) ||
			(op == fcas_pkg::OP_BLANK && e_lo >= fcas_pkg::DATA_END);
		// Word granularity: the low two end bits never matter
		chk.dir_err = op == fcas_pkg::OP_BLANK && (bc_dir ?
			e_lo[18:2] >= s_lo[18:2] : e_lo[18:2] <= s_lo[18:2]);
		chk.end_addr = {13'h0000, e_lo[18:2], 2'b00};
		case (op)
		fcas_pkg::OP_PROG_C: begin
			chk.addr = {8'h00, start[23:8], 8'h00};
		end
		fcas_pkg::OP_ERASE_C, fcas_pkg::OP_LOCK_PROG,
		fcas_pkg::OP_LOCK_READ: begin
			if (start[23:0] < fcas_pkg::SMALL_BLOCK_END) begin
				chk.addr = {8'h00, start[23:13], 13'h0000};
			end else begin
				chk.addr = {8'h00, start[23:15], 15'h0000};
			end
		end
		fcas_pkg::OP_ERASE_D: begin
			chk.addr = {13'h0000, s_lo[18:6], 6'h00};
		end
		fcas_pkg::OP_CFG, fcas_pkg::OP_OTP: begin
			chk.addr = {13'h0000, s_lo[18:4], 4'h0};
		end
		default: begin
			chk.addr = {13'h0000, s_lo[18:2], 2'b00};
		end
		endcase
	end
endmodule

/* core/fcas_ecc_buf.sv */
// Small first-in first-out store for dummy ECC words.
// Read data comes from a register; a write into an empty buffer bypasses.
`timescale 1ns/1ns
module fcas_ecc_buf (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [31:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [31:0] rd_data
);
	typedef struct packed {
		logic [fcas_pkg::ECC_DEPTH-1:0][31:0] mem;
		logic [fcas_pkg::ECC_PTR_W-1:0] wp;
		logic [fcas_pkg::ECC_PTR_W-1:0] rp;
		logic [fcas_pkg::ECC_PTR_W:0] cnt;
		logic [31:0] dout;
	} fcas_buf_t;

	fcas_buf_t s;
	fcas_buf_t next_s;
	logic push;
	logic pop;

	assign wr_ready = s.cnt != 3'(fcas_pkg::ECC_DEPTH);
	assign rd_valid = s.cnt != '0;
	assign rd_data = s.dout;

	always_comb begin
		next_s = s;
		push = wr_valid && wr_ready;
		pop = rd_valid && rd_ready;
		if (push) begin
			next_s.mem[s.wp] = wr_data;
			next_s.wp = s.wp + 1'b1;
		end
		if (pop) begin
			next_s.rp = s.rp + 1'b1;
		end
		next_s.cnt = s.cnt + {2'b00, push} - {2'b00, pop};
		next_s.dout = next_s.mem[next_s.rp];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

/* bench/fcas_top_assertions.sv */
// Port-level checker for the flash command sequencer.
// Sees only the top module's ports; attached by the bind at the foot.
`timescale 1ns/1ns
module fcas_top_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire fcas_pkg::fcas_bus_req_t bus,
	input wire logic bus_ack,
	input wire logic [31:0] bus_rdata,
	input wire fcas_pkg::fcas_core_cmd_t core_cmd,
	input wire fcas_pkg::fcas_core_rsp_t core_rsp,
	input wire logic ecc_valid,
	input wire logic [31:0] ecc_word
);
	// ----------------------------------------
	// Helpers and properties
	// ----------------------------------------
	logic stall_wr;
	logic st;
	fcas_pkg::fcas_op_t op;
	assign stall_wr = bus.wr && bus.addr[31:2] == fcas_pkg::DUMMY_ECC_ADDR[31:2];
	assign st = core_cmd.start;
	assign op = core_cmd.op;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	ack_once_a: assert property (bus_ack |=> !bus_ack)
		else $error("bus ack longer than one cycle");
	ack_cause_a: assert property (bus_ack |-> $past(bus.req))
		else $error("bus ack without request");
	take_answer_a: assert property (bus.req && !bus_ack && !stall_wr |=> bus_ack)
		else $error("request not answered in one cycle");
	start_pulse_a: assert property (st |-> bus_ack ##1 !st)
		else $error("start not a single pulse with ack");
	stop_code_a: assert property (core_cmd.stop |-> bus.wr && bus.wdata[7:0] == fcas_pkg::CMD_STOP)
		else $error("stop without stop code");
	code_align_a: assert property (st && op == fcas_pkg::OP_PROG_C |-> core_cmd.addr[31:24] == 8'h00 && core_cmd.addr[7:0] == 8'h00)
		else $error("code program address not truncated");
	data_align_a: assert property (st && op inside {fcas_pkg::OP_PROG_D, fcas_pkg::OP_DMA, fcas_pkg::OP_BLANK} |-> core_cmd.addr[31:19] == 13'h0 && core_cmd.addr[1:0] == 2'h0)
		else $error("data address not truncated");
	erase_align_a: assert property (st && op inside {fcas_pkg::OP_ERASE_C, fcas_pkg::OP_LOCK_PROG, fcas_pkg::OP_LOCK_READ} |-> core_cmd.addr[12:0] == 13'h0)
		else $error("block address not aligned");
	set_align_a: assert property (st && op inside {fcas_pkg::OP_CFG, fcas_pkg::OP_OTP} |-> core_cmd.addr[3:0] == 4'h0)
		else $error("setting address not aligned");
	blank_end_a: assert property (st && op == fcas_pkg::OP_BLANK |-> core_cmd.end_addr[31:19] == 13'h0 && core_cmd.end_addr[1:0] == 2'h0)
		else $error("blank end address not truncated");
	rdata_hold_a: assert property ($changed(bus_rdata) |-> bus_ack && !bus.wr)
		else $error("read data changed outside a read");
endmodule

bind fcas_top fcas_top_assertions u_sva (.clk(clk), .rst(rst), .bus(bus),
	.bus_ack(bus_ack), .bus_rdata(bus_rdata), .core_cmd(core_cmd),
	.core_rsp(core_rsp), .ecc_valid(ecc_valid), .ecc_word(ecc_word));

/* bench/fcas_core_model.sv */
// Behavioural flash core answering the sequencer's operations.
// Same clock; latency and error injection come from the bench.
`timescale 1ns/1ns
module fcas_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire fcas_pkg::fcas_core_cmd_t cmd,
	input wire logic ecc_valid,
	input wire logic pop_en,
	input wire logic [7:0] lat,
	input wire logic [1:0] inj,
	output fcas_pkg::fcas_core_rsp_t rsp
);
	// ----------------------------------------
	// Operation timer
	// ----------------------------------------
	logic [7:0] cnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			rsp <= '0;
		end else begin
			rsp.done <= cnt == 8'h01;
			rsp.otp_double <= cnt == 8'h03 && inj[1];
			rsp.otp_single <= cnt == 8'h03 && inj[0];
			// Every other cycle, so a stale valid never pops twice
			rsp.ecc_pop <= pop_en && ecc_valid && !rsp.ecc_pop;
			if (cmd.stop)
				cnt <= 8'h02;
			else if (cmd.start || cmd.resume)
				cnt <= lat;
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end
endmodule

/* bench/fcas_top_tb.sv */
// Self-checking bench of the flash command sequencer.
// Drives the register bus as host; the core model answers operations.
`timescale 1ns/1ns
module fcas_top_tb;
	logic clk;
	logic rst;
	fcas_pkg::fcas_bus_req_t bus;
	logic bus_ack;
	logic [31:0] bus_rdata;
	fcas_pkg::fcas_core_cmd_t core_cmd;
	fcas_pkg::fcas_core_rsp_t core_rsp;
	logic ecc_valid;
	logic [31:0] ecc_word;
	logic pop_en;
	logic [7:0] lat;
	logic [1:0] inj;
	logic [31:0] rnd;
	logic [31:0] rq[$];
	logic [31:0] aq[$];
	logic [31:0] eq[$];
	int n_mismatch;
	int checks;
	int waitc;

	fcas_top dut (.clk(clk), .rst(rst), .bus(bus), .bus_ack(bus_ack),
		.bus_rdata(bus_rdata), .core_cmd(core_cmd), .core_rsp(core_rsp),
		.ecc_valid(ecc_valid), .ecc_word(ecc_word));
	fcas_core_model core (.clk(clk), .rst(rst), .cmd(core_cmd),
		.ecc_valid(ecc_valid), .pop_en(pop_en), .lat(lat), .inj(inj),
		.rsp(core_rsp));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	task automatic test_done;
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Request held until the edge that samples ack, released just after
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		if (w && a == fcas_pkg::DUMMY_ECC_ADDR)
			eq.push_back(d);
		waitc = 0;
		@(posedge clk);
		#1;
		bus = '{1'b1, w, a, d, 4'hF};
		do begin
			@(posedge clk);
			waitc++;
		end while (bus_ack !== 1'b1 && waitc < 500);
		if (waitc >= 500)
			n_mismatch++;
		#1;
		bus.req = 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		rq.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic ca(input logic [7:0] c);
		xfer(1'b1, fcas_pkg::CMD_AREA_ADDR, {24'h0, c});
	endtask

	task automatic st(input logic [31:0] a);
		xfer(1'b1, fcas_pkg::START_ADDR, a);
	endtask

	// Bounded wait; a locked sequencer simply runs it out
	task automatic wdone;
		waitc = 0;
		while (core_rsp.done !== 1'b1 && waitc < 300) begin
			@(posedge clk);
			waitc++;
		end
		@(posedge clk);
	endtask

	task automatic go;
		ca(fcas_pkg::CMD_CONFIRM);
		wdone;
	endtask

	task automatic clr;
		xfer(1'b1, fcas_pkg::ACCESS_ADDR, 32'h0);
		ca(fcas_pkg::CMD_CLEAR);
	endtask

	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge clk) begin
		if (bus_ack === 1'b1 && bus.wr === 1'b0 && rq.size() > 0)
			cmp(rq.pop_front(), bus_rdata);
		if (core_cmd.start === 1'b1)
			cmp(aq.size() > 0 ? aq.pop_front() : ~core_cmd.addr, core_cmd.addr);
		if (core_rsp.ecc_pop === 1'b1 && ecc_valid === 1'b1)
			cmp(eq.pop_front(), ecc_word);
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		bus = '0;
		pop_en = 1'b0;
		lat = 8'h04;
		inj = 2'b00;
		rnd = 32'hADE1;
		n_mismatch = 0;
		checks = 0;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		rd(fcas_pkg::STATUS_ADDR, 32'h00008000);
		xfer(1'b1, fcas_pkg::STATUS_ADDR, 32'h0);
		rd(fcas_pkg::STATUS_ADDR + 32'h2, 32'h00008000);
		st(32'h00001234);
		xfer(1'b1, fcas_pkg::SETUP_ADDR, 32'h1);
		xfer(1'b1, fcas_pkg::SETUP_ADDR, 32'h0);
		rd(fcas_pkg::START_ADDR, 32'h0);
		xfer(1'b1, fcas_pkg::ENTRY_ADDR, 32'h0000AA01);
		// Slow core: ready low from the first write to the end
		rnd = lfsr(rnd);
		lat = 8'h28;
		st(rnd & 32'hFF1FFFFF);
		aq.push_back(rnd & 32'h001FFF00);
		ca(fcas_pkg::CMD_PROG);
		rd(fcas_pkg::STATUS_ADDR, 32'h0);
		ca(fcas_pkg::CMD_CONFIRM);
		rd(fcas_pkg::STATUS_ADDR, 32'h0);
		wdone;
		rd(fcas_pkg::STATUS_ADDR, 32'h00008000);
		// Erase: ready stays high until confirm; single error corrected
		lat = 8'h04;
		inj = 2'b01;
		rnd = lfsr(rnd);
		st(rnd & 32'h0000FFFF);
		aq.push_back(rnd & 32'h0000E000);
		ca(fcas_pkg::CMD_ERASE);
		rd(fcas_pkg::STATUS_ADDR, 32'h00008000);
		go;
		rd(fcas_pkg::STATUS_ADDR, 32'h00018000);
		ca(fcas_pkg::CMD_CLEAR);
		rd(fcas_pkg::STATUS_ADDR, 32'h00008000);
		// Setting command with a double error, then forced stop
		inj = 2'b10;
		st(32'h0000004F);
		aq.push_back(32'h00000040);
		ca(fcas_pkg::CMD_OTP);
		go;
		rd(fcas_pkg::STATUS_ADDR, 32'h00028000);
		ca(fcas_pkg::CMD_ERASE);
		rd(fcas_pkg::STATUS_ADDR, 32'h00028000);
		inj = 2'b00;
		ca(fcas_pkg::CMD_STOP);
		wdone;
		rd(fcas_pkg::STATUS_ADDR, 32'h00008000);
		// Code address beyond the array locks the sequencer
		st(32'h00300000);
		ca(fcas_pkg::CMD_ERASE);
		rd(fcas_pkg::STATUS_ADDR, 32'h0000C000);
		go;
		ca(fcas_pkg::CMD_CLEAR);
		rd(fcas_pkg::STATUS_ADDR, 32'h0000C000);
		clr;
		rd(fcas_pkg::STATUS_ADDR, 32'h00008000);
		st(32'h00000030);
		ca(fcas_pkg::CMD_CFG);
		rd(fcas_pkg::STATUS_ADDR, 32'h0000C000);
		clr;
		// Data mode
		xfer(1'b1, fcas_pkg::ENTRY_ADDR, 32'h0000AA80);
		rnd = lfsr(rnd);
		st(rnd & 32'hFFF8FFFF);
		aq.push_back(rnd & 32'h0000FFFC);
		ca(fcas_pkg::CMD_PROG);
		go;
		st(32'h00000100);
		xfer(1'b1, fcas_pkg::END_ADDR, 32'hFFF80203);
		xfer(1'b1, fcas_pkg::BLANK_CTRL_ADDR, 32'h0);
		aq.push_back(32'h00000100);
		ca(fcas_pkg::CMD_BLANK);
		go;
		xfer(1'b1, fcas_pkg::BLANK_CTRL_ADDR, 32'h1);
		ca(fcas_pkg::CMD_BLANK);
		rd(fcas_pkg::STATUS_ADDR, 32'h0000C000);
		clr;
		xfer(1'b1, fcas_pkg::END_ADDR, 32'h00010200);
		xfer(1'b1, fcas_pkg::BLANK_CTRL_ADDR, 32'h0);
		ca(fcas_pkg::CMD_BLANK);
		rd(fcas_pkg::STATUS_ADDR, 32'h0000C000);
		clr;
		st(32'h00012345);
		ca(fcas_pkg::CMD_PROG);
		rd(fcas_pkg::STATUS_ADDR, 32'h0000C000);
		clr;
		rd(fcas_pkg::STATUS_ADDR, 32'h00008000);
		// Fill the ECC buffer, stall on the next write, then drain
		repeat (4) xfer(1'b1, fcas_pkg::DUMMY_ECC_ADDR, lfsr(rnd));
		rd(fcas_pkg::STATUS_ADDR, 32'h00048000);
		fork
			#300 pop_en = 1'b1;
		join_none
		xfer(1'b1, fcas_pkg::DUMMY_ECC_ADDR, 32'h5);
		cmp(32'(waitc > 20), 32'h1);
		repeat (20) @(posedge clk);
		rd(fcas_pkg::STATUS_ADDR, 32'h00008000);
		xfer(1'b1, fcas_pkg::REGION_ADDR, 32'h0000A502);
		rd(fcas_pkg::REGION_ADDR, 32'h2);
		test_done;
	end

	initial begin
		#200000;
		n_mismatch++;
		test_done;
	end
endmodule
